// ---- verilog/ccu_top.sv ----
// Capture and compare channel with its shared timer and register port.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module ccu_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire ccu_pkg::ccu_bus_req_type bus_req,
  output logic [7:0] rd_data,
  input wire logic channel_pin_in,
  output logic channel_pin_out,
  output logic channel_pin_oe,
  input wire logic ext_timer_tick,
  input wire logic sleep,
  output logic special_trigger,
  output logic [15:0] timer_count,
  output logic irq
);

  // ---------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------
  logic [ccu_pkg::CTRL_W-1:0] control; // Duty bits and mode select.
  logic [15:0] value; // Channel value pair.
  logic flag; // Sticky channel event flag.
  logic mask; // Interrupt enable for the event flag.
  logic timer_on; // Timer runs.
  logic timer_ext; // Timer counts external ticks.
  logic [15:0] timer; // Shared timer count.
  logic [1:0] div; // Instruction clock divider.
  logic sync1, sync2, pin_d; // Pin synchroniser and edge history.
  logic [3:0] pscnt; // Capture prescaler counter.
  logic out_latch; // Compare output latch.
  logic match_d; // Match seen last cycle.
  logic reset_pend; // Timer reset waits for the next tick.
  logic trig; // Registered special event pulse.

  logic [ccu_pkg::CTRL_W-1:0] next_control;
  logic [15:0] next_value;
  logic next_flag, next_mask, next_timer_on, next_timer_ext;
  logic [15:0] next_timer;
  logic [1:0] next_div;
  logic [3:0] next_pscnt;
  logic next_out_latch, next_match_d, next_reset_pend, next_trig;
  logic [7:0] next_rd_data;

  // Decoded helpers.
  ccu_pkg::ccu_mode_type mode;
  logic is_capture, is_compare, drives_pin;
  logic rise, fall, edge_hit, cap_event, match, cmp_event, advance;
  logic [3:0] ps_mask;

  // ---------------------------------------------------------------------
  // Functions.
  // ---------------------------------------------------------------------
  // A write strobe aimed at one offset.
  function automatic logic wr_at(input ccu_pkg::ccu_bus_req_type r,
                                 input logic [ccu_pkg::ADDR_W-1:0] a);
    wr_at = r.wr && (r.addr == a);
  endfunction : wr_at

  // Merge a byte write into one half of a 16-bit pair.
  function automatic logic [15:0] put_byte(input logic [15:0] old,
                                           input logic [7:0] b,
                                           input logic high);
    put_byte = high ? {b, old[7:0]} : {old[15:8], b};
  endfunction : put_byte

  // ---------------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------------
  // All state of the channel except the pin synchroniser is computed here and registered below.
  always_comb begin
    mode = ccu_pkg::ccu_mode_type'(control[3:0]);
    is_capture = (control[3:2] == 2'b01);
    is_compare = (mode == ccu_pkg::MODE_CMP_TOGGLE) ||
                 (mode == ccu_pkg::MODE_CMP_SET) ||
                 (mode == ccu_pkg::MODE_CMP_CLEAR) ||
                 (mode == ccu_pkg::MODE_CMP_SOFT) ||
                 (mode == ccu_pkg::MODE_CMP_TRIGGER);
    // Only toggle, set and clear take control of the pin.
    drives_pin = (mode == ccu_pkg::MODE_CMP_TOGGLE) ||
                 (mode == ccu_pkg::MODE_CMP_SET) ||
                 (mode == ccu_pkg::MODE_CMP_CLEAR);
    // Edges are seen only on the second synchroniser stage.
    rise = sync2 && !pin_d;
    fall = !sync2 && pin_d;
    // The edge chosen by the capture code.
    edge_hit = is_capture &&
               ((mode == ccu_pkg::MODE_CAP_FALL) ? fall : rise);
    // Prescaler mask: every edge, every 4th or every 16th.
    case (mode)
      ccu_pkg::MODE_CAP_RISE4: ps_mask = ccu_pkg::PRESCALE_MASK_4;
      ccu_pkg::MODE_CAP_RISE16: ps_mask = ccu_pkg::PRESCALE_MASK_16;
      default: ps_mask = ccu_pkg::PRESCALE_MASK_1;
    endcase
    // The counter is compared under the mask, so a switch between
    // prescalers keeps its count and may fire early.
    cap_event = edge_hit && ((pscnt & ps_mask) == ps_mask);
    // Continuous equality of the pair against the timer.
    match = is_compare && (timer == value);
    // One event per match episode, so a stalled timer flags only once.
    cmp_event = match && !match_d;
    // Internal ticks stop in sleep; external ticks do not.
    advance = timer_on && (timer_ext ? ext_timer_tick :
              ((div == ccu_pkg::INSTR_DIV_LAST) && !sleep));

    // Prescaler counter: free wrap, zero outside capture.
    if (!is_capture) begin
      next_pscnt = ccu_pkg::PRESCALE_RESET;
    end else if (edge_hit) begin
      next_pscnt = pscnt + 4'h1;
    end else begin
      next_pscnt = pscnt;
    end

    // The divider freezes in sleep so the timer resumes in place.
    if (sleep) begin
      next_div = div;
    end else begin
      next_div = div + 2'h1;
    end

    // Control register: duty bits are stored and read back only.
    next_control = control;
    if (wr_at(bus_req, ccu_pkg::OFF_CONTROL)) begin
      next_control = bus_req.wdata[ccu_pkg::CTRL_W-1:0];
    end

    // Value pair: a capture overwrites whatever was there.
    next_value = value;
    if (cap_event) begin
      next_value = timer;
    end else if (wr_at(bus_req, ccu_pkg::OFF_VALUE_LOW)) begin
      next_value = put_byte(value, bus_req.wdata, 1'b0);
    end else if (wr_at(bus_req, ccu_pkg::OFF_VALUE_HIGH)) begin
      next_value = put_byte(value, bus_req.wdata, 1'b1);
    end

    // Flag: hardware only sets; a written one clears; set wins.
    next_flag = flag;
    if (wr_at(bus_req, ccu_pkg::OFF_STATUS) &&
        bus_req.wdata[ccu_pkg::FLAG_BIT]) begin
      next_flag = 1'b0;
    end
    if (cap_event || cmp_event) begin
      next_flag = 1'b1;
    end

    // Mask register.
    next_mask = mask;
    if (wr_at(bus_req, ccu_pkg::OFF_MASK)) begin
      next_mask = bus_req.wdata[ccu_pkg::FLAG_BIT];
    end

    // Timer control.
    next_timer_on = timer_on;
    next_timer_ext = timer_ext;
    if (wr_at(bus_req, ccu_pkg::OFF_TIMER_CTRL)) begin
      next_timer_on = bus_req.wdata[ccu_pkg::TIMER_ON_BIT];
      next_timer_ext = bus_req.wdata[ccu_pkg::TIMER_EXT_BIT];
    end

    // Compare output latch; turning the channel off forces it low.
    next_out_latch = out_latch;
    if (mode == ccu_pkg::MODE_OFF) begin
      next_out_latch = 1'b0;
    end else if (cmp_event) begin
      case (mode)
        ccu_pkg::MODE_CMP_TOGGLE: next_out_latch = !out_latch;
        ccu_pkg::MODE_CMP_SET: next_out_latch = 1'b1;
        ccu_pkg::MODE_CMP_CLEAR: next_out_latch = 1'b0;
        default: next_out_latch = out_latch;
      endcase
    end
    next_match_d = match;

    // Special trigger: pulse now, reset the timer on its next tick,
    // unless software removes the match in between.
    next_trig = cmp_event && (mode == ccu_pkg::MODE_CMP_TRIGGER);
    next_reset_pend = reset_pend;
    if (next_trig) begin
      next_reset_pend = 1'b1;
    end else if (advance || !match) begin
      next_reset_pend = 1'b0;
    end

    // Shared timer count; software writes win over counting.
    next_timer = timer;
    if (wr_at(bus_req, ccu_pkg::OFF_TIMER_LOW)) begin
      next_timer = put_byte(timer, bus_req.wdata, 1'b0);
    end else if (wr_at(bus_req, ccu_pkg::OFF_TIMER_HIGH)) begin
      next_timer = put_byte(timer, bus_req.wdata, 1'b1);
    end else if (advance && match && (reset_pend || next_trig)) begin
      // A tick in the trigger's own cycle already counts as the next one.
      next_timer = ccu_pkg::VALUE_RESET;
    end else if (advance) begin
      next_timer = timer + 16'h0001;
    end

    // Read data for the cycle after the strobe; unmapped reads zero.
    next_rd_data = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        ccu_pkg::OFF_CONTROL: next_rd_data = {2'b00, control};
        ccu_pkg::OFF_VALUE_LOW: next_rd_data = value[7:0];
        ccu_pkg::OFF_VALUE_HIGH: next_rd_data = value[15:8];
        ccu_pkg::OFF_STATUS: next_rd_data = {7'h00, flag};
        ccu_pkg::OFF_MASK: next_rd_data = {7'h00, mask};
        ccu_pkg::OFF_TIMER_CTRL: next_rd_data = {6'h00, timer_ext, timer_on};
        ccu_pkg::OFF_TIMER_LOW: next_rd_data = timer[7:0];
        ccu_pkg::OFF_TIMER_HIGH: next_rd_data = timer[15:8];
        default: next_rd_data = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Registers.
  // ---------------------------------------------------------------------
  // Every reset source lands here and clears all state.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control <= ccu_pkg::CONTROL_RESET;
      value <= ccu_pkg::VALUE_RESET;
      flag <= 1'b0;
      mask <= 1'b0;
      timer_on <= 1'b0;
      timer_ext <= 1'b0;
      timer <= ccu_pkg::VALUE_RESET;
      div <= 2'h0;
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      pin_d <= 1'b0;
      pscnt <= ccu_pkg::PRESCALE_RESET;
      out_latch <= 1'b0;
      match_d <= 1'b0;
      reset_pend <= 1'b0;
      trig <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      control <= next_control;
      value <= next_value;
      flag <= next_flag;
      mask <= next_mask;
      timer_on <= next_timer_on;
      timer_ext <= next_timer_ext;
      timer <= next_timer;
      div <= next_div;
      sync1 <= channel_pin_in;
      sync2 <= sync1;
      pin_d <= sync2;
      pscnt <= next_pscnt;
      out_latch <= next_out_latch;
      match_d <= next_match_d;
      reset_pend <= next_reset_pend;
      trig <= next_trig;
      rd_data <= next_rd_data;
    end
  end

  // Outputs; the enable is a plain combinational decode of the mode.
  assign channel_pin_out = out_latch;
  assign channel_pin_oe = drives_pin;
  assign special_trigger = trig;
  assign timer_count = timer;
  assign irq = flag && mask;

  // ---------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_PS_ZERO: assert property (!is_capture |=> pscnt == 4'h0)
    else $error("Prescaler not zero outside capture.");
  AST_PS_RESET: assert property ($past(rst) |-> pscnt == 4'h0)
    else $error("Prescaler not cleared by reset.");
  AST_CAP_VALUE: assert property (cap_event |=> value == $past(timer))
    else $error("Capture did not copy the timer.");
  AST_CAP_FLAG: assert property (cap_event |=> flag)
    else $error("Capture did not set the flag.");
  AST_FLAG_HOLD: assert property (flag && !(bus_req.wr &&
      bus_req.addr == ccu_pkg::OFF_STATUS) |=> flag)
    else $error("Flag dropped without a software clear.");
  AST_CMP_FLAG: assert property ($rose(match) |=> flag)
    else $error("Compare match did not set the flag.");
  AST_CMP_SET: assert property (cmp_event &&
      mode == ccu_pkg::MODE_CMP_SET |=> channel_pin_out)
    else $error("Set-on-match left the pin low.");
  AST_CMP_TOGGLE: assert property (cmp_event &&
      mode == ccu_pkg::MODE_CMP_TOGGLE |=>
      channel_pin_out != $past(channel_pin_out))
    else $error("Toggle-on-match did not toggle.");
  AST_SLEEP_HOLD: assert property (sleep && !timer_ext &&
      !bus_req.wr |=> timer == $past(timer))
    else $error("Internal timer moved during sleep.");
  AST_RISE4: assert property (mode == ccu_pkg::MODE_CAP_RISE4 &&
      $stable(control) && rise && pscnt[1:0] != 2'b11
      |-> !cap_event)
    else $error("Every-4th capture fired early.");
  AST_TRIG_PULSE: assert property (special_trigger |=>
      !special_trigger)
    else $error("Special trigger longer than one cycle.");

  // Match actions on the pin latch and on the shared timer.
  AST_CMP_CLEAR: assert property (cmp_event &&
      mode == ccu_pkg::MODE_CMP_CLEAR |=> !channel_pin_out)
    else $error("Clear-on-match left the pin high.");
  AST_PIN_FREE: assert property (mode == ccu_pkg::MODE_CMP_SOFT ||
      mode == ccu_pkg::MODE_CMP_TRIGGER |=> $stable(channel_pin_out))
    else $error("Pin latch moved in a pin-free compare mode.");
  AST_TRIG_CLEAR: assert property (reset_pend && match && advance &&
      !bus_req.wr |=> timer == 16'h0000)
    else $error("Special event did not reset the timer.");

  COV_CAPTURE: cover property (cap_event ##1 flag);
  COV_RISE16: cover property (mode == ccu_pkg::MODE_CAP_RISE16 && cap_event);
  COV_TRIGGER: cover property (special_trigger ##[1:8] timer == 16'h0000);
  COV_IRQ: cover property ($rose(irq));

endmodule : ccu_top

`default_nettype wire

// ---- verilog/ccu_pkg.sv ----
// Package with the constants, types and register map of the channel block.
package ccu_pkg;

  // ---------------------------------------------------------------------
  // Bus widths and the request carrier.
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // One register bus request, as the master drives it in one cycle.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ccu_bus_req_type;

  // ---------------------------------------------------------------------
  // Register offsets.
  // ---------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_VALUE_LOW = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_VALUE_HIGH = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_TIMER_CTRL = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_TIMER_LOW = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_TIMER_HIGH = 4'h7;

  // ---------------------------------------------------------------------
  // Field positions and reset values.
  // ---------------------------------------------------------------------
  localparam int CTRL_W = 6;
  localparam int FLAG_BIT = 0;
  localparam int TIMER_ON_BIT = 0;
  localparam int TIMER_EXT_BIT = 1;
  localparam logic [CTRL_W-1:0] CONTROL_RESET = 6'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [3:0] PRESCALE_RESET = 4'h0;
  localparam logic [3:0] PRESCALE_MASK_4 = 4'h3;
  localparam logic [3:0] PRESCALE_MASK_16 = 4'hF;
  localparam logic [3:0] PRESCALE_MASK_1 = 4'h0;

  // ---------------------------------------------------------------------
  // Timing: the instruction clock is the system clock divided by four.
  // ---------------------------------------------------------------------
  localparam int SYS_CLK_HZ = 25000000;
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_DIV - 1);

  // ---------------------------------------------------------------------
  // Channel mode select codes.
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_OFF = 4'h0,
    MODE_CMP_TOGGLE = 4'h2,
    MODE_CAP_FALL = 4'h4,
    MODE_CAP_RISE = 4'h5,
    MODE_CAP_RISE4 = 4'h6,
    MODE_CAP_RISE16 = 4'h7,
    MODE_CMP_SET = 4'h8,
    MODE_CMP_CLEAR = 4'h9,
    MODE_CMP_SOFT = 4'hA,
    MODE_CMP_TRIGGER = 4'hB
  } ccu_mode_type;

endpackage : ccu_pkg

// ---- verif/ccu_pin_src.sv ----
// Partner model: outside event source on the channel pin and timer ticks.
`timescale 1ns/1ps
`default_nettype none

module ccu_pin_src (
  input wire logic sys_clk,
  output logic level,
  output logic tick
);
  // ---------------------------------------------------------------
  // Pin and tick drivers.
  // ---------------------------------------------------------------
  // The pin idles low and the tick stays quiet until commanded.
  initial begin
    level = 1'b0;
    tick = 1'b0;
  end

  // Moves the pin just after an edge and holds the level; a long hold
  // plays a slow source, a short one a prompt source.
  task automatic drive(input logic lv, input int hold);
    @(posedge sys_clk);
    level <= lv;
    repeat (hold) @(posedge sys_clk);
  endtask : drive

  // One tick from an outside clock, synchronous to the system clock and
  // never the raw oscillator itself.
  task automatic tick_once();
    @(posedge sys_clk);
    tick <= 1'b1;
    @(posedge sys_clk);
    tick <= 1'b0;
  endtask : tick_once
endmodule : ccu_pin_src
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking testbench of the capture and compare channel.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ---------------------------------------------------------------
  // Signals and design hookup.
  // ---------------------------------------------------------------
  localparam int CEIL = 20000; // The tests need about 600 cycles.
  localparam logic [3:0] A_CTL = ccu_pkg::OFF_CONTROL;
  localparam logic [3:0] A_VLO = ccu_pkg::OFF_VALUE_LOW;
  localparam logic [3:0] A_STS = ccu_pkg::OFF_STATUS;
  localparam logic [3:0] A_TLO = ccu_pkg::OFF_TIMER_LOW;
  logic sys_clk;
  logic rst;
  ccu_pkg::ccu_bus_req_type bus_req;
  logic [7:0] rd_data;
  logic pin_wire; // Resolved pin level.
  logic src_level;
  logic src_tick;
  logic pin_out;
  logic pin_oe;
  logic sleep;
  logic trig;
  logic [15:0] timer_count;
  logic irq;
  int fails;
  int comparisons;
  int cycles;
  int trig_seen; // Trigger pulses since the last clear.
  int m_pin; // Model of the compare output latch.
  int m_flag; // Model of the event flag.

  // The design owns the pin while its enable is high.
  assign pin_wire = pin_oe ? pin_out : src_level;

  ccu_top ccu_top_inst (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req),
    .rd_data(rd_data), .channel_pin_in(pin_wire), .channel_pin_out(pin_out),
    .channel_pin_oe(pin_oe), .ext_timer_tick(src_tick), .sleep(sleep),
    .special_trigger(trig), .timer_count(timer_count), .irq(irq));
  ccu_pin_src ccu_pin_src_inst (.sys_clk(sys_clk), .level(src_level),
    .tick(src_tick));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Counts cycles and trigger pulses; a hang ends the run as a failure.
  always @(posedge sys_clk) begin
    cycles++;
    if (trig === 1'b1) trig_seen++;
    if (cycles == CEIL) begin
      fails++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Tasks.
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Waits n edges and lets their updates land.
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // One-cycle write; the strobe drops at the edge that takes it.
  task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask : bus_write

  // One-cycle read; the data stand only in the following cycle.
  task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask : bus_read

  // Sixteen-bit values travel as two separate bytes, low byte first.
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    bus_write(a, v[7:0]);
    bus_write(4'(a + 4'h1), v[15:8]);
  endtask : wr16

  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    bus_read(a, v[7:0]);
    bus_read(4'(a + 4'h1), v[15:8]);
  endtask : rd16

  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic [15:0] t;
    logic [15:0] v;
    logic [3:0] cmp_modes [5];
    logic [15:0] want; // Expected value of the next comparison.
    cmp_modes = '{4'h2, 4'h8, 4'h9, 4'hA, 4'hB};
    bus_req = '0;
    rst = 1'b1;
    sleep = 1'b0;
    fails = 0;
    comparisons = 0;
    cycles = 0;
    trig_seen = 0;
    void'($urandom(32'he758f539));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values everywhere; an unmapped write must not stick.
    bus_write(4'h9, 8'hA5);
    for (int a = 0; a < 16; a++) begin
      bus_read(4'(a), d);
      check("reg_reset", {8'h00, d}, 16'h0000);
    end
    bus_write(A_CTL, 8'hFF);
    bus_read(A_CTL, d);
    check("ctrl_bits", {8'h00, d}, 16'h003F);
    bus_write(A_CTL, 8'h00);
    $display("test registers done");
    // Rising-edge capture on external ticks, run while asleep.
    bus_write(ccu_pkg::OFF_TIMER_CTRL, 8'h03);
    bus_write(ccu_pkg::OFF_MASK, 8'h01);
    bus_write(A_CTL, 8'h05);
    sleep <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      t = 16'($urandom);
      wr16(A_TLO, t);
      bus_write(A_STS, 8'h01); // Drop any spurious flag.
      check("timer_load", timer_count, t);
      check("irq_clear", {15'h0, irq}, 16'h0000);
      ccu_pin_src_inst.drive(1'b0, 3);
      ccu_pin_src_inst.drive(1'b1, 6);
      m_flag = 1;
      rd16(A_VLO, v);
      check("cap_value", v, t);
      bus_read(A_STS, d);
      check("cap_flag", {15'h0, d[0]}, 16'(m_flag));
      check("irq_set", {15'h0, irq}, 16'h0001);
    end
    bus_write(A_STS, 8'h00);
    bus_read(A_STS, d);
    check("flag_sticky", {15'h0, d[0]}, 16'h0001);
    bus_write(A_STS, 8'h01);
    check("irq_cleared", {15'h0, irq}, 16'h0000);
    sleep <= 1'b0;
    $display("test capture rising done");
    // Falling-edge capture ignores rising edges.
    bus_write(A_CTL, 8'h00);
    bus_write(A_CTL, 8'h04);
    bus_write(A_STS, 8'h01);
    t = 16'($urandom);
    wr16(A_TLO, t);
    ccu_pin_src_inst.drive(1'b0, 6);
    rd16(A_VLO, v);
    check("fall_value", v, t);
    bus_write(A_STS, 8'h01);
    ccu_pin_src_inst.drive(1'b1, 6);
    bus_read(A_STS, d);
    check("fall_ignores_rise", {15'h0, d[0]}, 16'h0000);
    $display("test capture falling done");
    // Every fourth and every sixteenth rising edge.
    for (int p = 0; p < 2; p++) begin
      bus_write(A_CTL, 8'h00); // Off first clears the prescaler.
      bus_write(A_CTL, (p == 1) ? 8'h07 : 8'h06);
      bus_write(A_STS, 8'h01);
      for (int e = 1; e <= ((p == 1) ? 16 : 4); e++) begin
        ccu_pin_src_inst.drive(1'b0, 2);
        ccu_pin_src_inst.drive(1'b1, 4);
        bus_read(A_STS, d);
        want = 16'(e == ((p == 1) ? 16 : 4));
        check("prescale", {15'h0, d[0]}, want);
      end
    end
    // A direct switch keeps the count: three edges at every 16th leave
    // it at three, so the first edge at every 4th captures at once.
    for (int e = 0; e < 4; e++) begin
      if (e == 3) bus_write(A_CTL, 8'h06);
      bus_write(A_STS, 8'h01);
      ccu_pin_src_inst.drive(1'b0, 2);
      ccu_pin_src_inst.drive(1'b1, 4);
      bus_read(A_STS, d);
      check("prescale_keep", {15'h0, d[0]}, 16'(e == 3));
    end
    $display("test prescaler done");
    // Each compare action on a match made by one external tick.
    for (int i = 0; i < 5; i++) begin
      bus_write(A_CTL, 8'h00);
      m_pin = 0; // Clearing the control forces the latch low.
      t = 16'($urandom_range(16'hFFF0));
      wr16(A_TLO, t);
      wr16(A_VLO, t + 16'h0001);
      bus_write(A_CTL, {4'h0, cmp_modes[i]});
      bus_write(A_STS, 8'h01);
      trig_seen = 0;
      bus_read(A_STS, d);
      check("no_early_match", {15'h0, d[0]}, 16'h0000);
      ccu_pin_src_inst.tick_once();
      cyc(3);
      if (cmp_modes[i] == 4'h2) m_pin = 1 - m_pin;
      if (cmp_modes[i] == 4'h8) m_pin = 1;
      bus_read(A_STS, d);
      check("cmp_flag", {15'h0, d[0]}, 16'h0001);
      check("cmp_pin", {15'h0, pin_out}, 16'(m_pin));
      want = 16'(cmp_modes[i] inside {4'h2, 4'h8, 4'h9});
      check("cmp_oe", {15'h0, pin_oe}, want);
      check("cmp_trig", 16'(trig_seen), 16'(cmp_modes[i] == 4'hB));
      ccu_pin_src_inst.tick_once();
      cyc(2);
      want = (cmp_modes[i] == 4'hB) ? 16'h0000 : t + 16'h0002;
      check("cmp_timer", timer_count, want);
    end
    $display("test compare done");
    // Internal ticks stop in sleep and resume from the held count.
    bus_write(A_CTL, 8'h00);
    bus_write(ccu_pkg::OFF_TIMER_CTRL, 8'h01);
    sleep <= 1'b1;
    cyc(2);
    v = timer_count;
    cyc(20);
    check("sleep_hold", timer_count, v);
    sleep <= 1'b0;
    cyc(20);
    want = 16'((timer_count - v) inside {[16'h4 : 16'h6]});
    check("wake_run", want, 16'h0001);
    $display("test sleep done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
